// >>> verilog/aiobo_top.sv
// Analogue input path, analogue output selection and motor brake sequencer
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module aiobo_top #(
   parameter int unsigned FB_CYCLES = aiobo_pkg::FB_CYCLES,
   parameter int unsigned MS_CYCLES = aiobo_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // Register port
   input wire logic [7:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   output logic IRQ,
   // Converter pins and drive-side timing
   input wire logic [1:0][15:0] ADC_DATA,
   input wire logic TCTRL_TICK,
   output logic [1:0] ADC_SAMPLE,
   output logic [1:0][15:0] REF_DATA,
   output logic [1:0] PROF_REF_VALID,
   output logic [1:0] DIRECT_REF_VALID,
   output logic CABLE_BREAK_ERR,
   output logic [1:0] CABLE_BREAK_REACTION,
   // Analogue output sources and values
   input wire aiobo_pkg::aiobo_src_t SRC,
   output logic [1:0][15:0] AOUT,
   // Brake
   input wire logic BRAKE_RELEASE_REQ,
   input wire logic FUNC_LEVEL,
   input wire aiobo_pkg::aiobo_brk_sense_t BRK_SENSE,
   output logic BRAKE_OUT,
   output logic DOUT_BRAKE,
   output logic TORQUE_EN,
   output logic [2:0] BRAKE_PHASE
);
   logic [31:0] ctrl_ff;
   logic [11:0] filt_cfg_ff;
   logic [15:0] ipts_ff;
   logic [1:0][15:0] thr_ff;
   logic [7:0] aosel_ff;
   logic [1:0][15:0] ao_scale_ff;
   logic [1:0][15:0] ao_off_ff;
   logic [15:0] param_ff;
   logic [7:0] brkfn_ff;
   logic [15:0] t_lift_ff, t_close_ff, t_rise_ff, t_fade_ff;
   logic [aiobo_pkg::EV_N-1:0] irq_stat_ff, irq_en_ff, fault_ff, ev_set;
   logic [31:0] rdata_ff;
   logic [17:0] fb_cnt_ff, ms_cnt_ff;
   logic fb_tick, ms_tick;
   logic [1:0][15:0] adc_s1_ff, adc_s2_ff;
   logic [1:0] sense_s1_ff, sense_s2_ff;
   logic [1:0] sample;
   logic [1:0][15:0] ao_src;
   aiobo_pkg::aiobo_brk_state_t brk_ff, nxt_brk;
   logic [15:0] tmr_ff;
   logic brake_out_ff, dout_brake_ff, torque_en_ff;
   logic direct, sup_en, dig_brake, brk_fn_sel, seq_run, sup_active, err_rst;
   logic cur_bad, wire_bad;

   assign direct = ctrl_ff[aiobo_pkg::CTRL_DIRECT_BIT];
   assign sup_en = ctrl_ff[aiobo_pkg::CTRL_SUP_BIT];
   assign dig_brake = ctrl_ff[aiobo_pkg::CTRL_DIGBRK_BIT];
   assign brk_fn_sel = (brkfn_ff == aiobo_pkg::BRAKE_FUNC_CODE);
   assign seq_run = brk_fn_sel | dig_brake;
   assign sup_active = sup_en & brk_fn_sel;
   assign err_rst = WR && (ADDR == aiobo_pkg::REG_ERR_RST) && WDATA[0];

   // Register writes
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         ctrl_ff <= aiobo_pkg::CTRL_RESET;
         filt_cfg_ff <= 12'h000;
         ipts_ff <= 16'h0000;
         thr_ff <= '0;
         aosel_ff <= 8'h00;
         ao_scale_ff <= {aiobo_pkg::SCALE_RESET, aiobo_pkg::SCALE_RESET};
         ao_off_ff <= '0;
         param_ff <= 16'h0000;
         brkfn_ff <= 8'h00;
         t_lift_ff <= 16'h0000;
         t_close_ff <= 16'h0000;
         t_rise_ff <= 16'h0000;
         t_fade_ff <= 16'h0000;
         irq_en_ff <= '0;
      end else if (WR) begin
         if (ADDR == aiobo_pkg::REG_CTRL) begin
            ctrl_ff <= WDATA;
         end else if (ADDR == aiobo_pkg::REG_FILT) begin
            filt_cfg_ff <= WDATA[11:0];
         end else if (ADDR == aiobo_pkg::REG_IPTS) begin
            ipts_ff <= WDATA[15:0];
         end else if (ADDR == aiobo_pkg::REG_THR0) begin
            thr_ff[0] <= WDATA[15:0];
         end else if (ADDR == aiobo_pkg::REG_THR1) begin
            thr_ff[1] <= WDATA[15:0];
         end else if (ADDR == aiobo_pkg::REG_AOSEL) begin
            aosel_ff <= WDATA[7:0];
         end else if (ADDR == aiobo_pkg::REG_AOSC0) begin
            ao_scale_ff[0] <= WDATA[15:0];
            ao_off_ff[0] <= WDATA[31:16];
         end else if (ADDR == aiobo_pkg::REG_AOSC1) begin
            ao_scale_ff[1] <= WDATA[15:0];
            ao_off_ff[1] <= WDATA[31:16];
         end else if (ADDR == aiobo_pkg::REG_PARAM) begin
            param_ff <= WDATA[15:0];
         end else if (ADDR == aiobo_pkg::REG_BRKFN) begin
            brkfn_ff <= WDATA[7:0];
         end else if (ADDR == aiobo_pkg::REG_BRKT0) begin
            t_lift_ff <= WDATA[15:0];
            t_close_ff <= WDATA[31:16];
         end else if (ADDR == aiobo_pkg::REG_BRKT1) begin
            t_rise_ff <= WDATA[15:0];
            t_fade_ff <= WDATA[31:16];
         end else if (ADDR == aiobo_pkg::REG_IRQ_EN) begin
            irq_en_ff <= WDATA[aiobo_pkg::EV_N-1:0];
         end
      end
   end

   // Read data, valid only in the cycle after the read strobe
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         rdata_ff <= 32'h0000_0000;
      end else if (!RD) begin
         rdata_ff <= 32'h0000_0000;
      end else if (ADDR == aiobo_pkg::REG_CTRL) begin
         rdata_ff <= ctrl_ff;
      end else if (ADDR == aiobo_pkg::REG_FILT) begin
         rdata_ff <= {20'h00000, filt_cfg_ff};
      end else if (ADDR == aiobo_pkg::REG_IPTS) begin
         rdata_ff <= {16'h0000, ipts_ff};
      end else if (ADDR == aiobo_pkg::REG_THR0) begin
         rdata_ff <= {16'h0000, thr_ff[0]};
      end else if (ADDR == aiobo_pkg::REG_THR1) begin
         rdata_ff <= {16'h0000, thr_ff[1]};
      end else if (ADDR == aiobo_pkg::REG_AOSEL) begin
         rdata_ff <= {24'h000000, aosel_ff};
      end else if (ADDR == aiobo_pkg::REG_AOSC0) begin
         rdata_ff <= {ao_off_ff[0], ao_scale_ff[0]};
      end else if (ADDR == aiobo_pkg::REG_AOSC1) begin
         rdata_ff <= {ao_off_ff[1], ao_scale_ff[1]};
      end else if (ADDR == aiobo_pkg::REG_PARAM) begin
         rdata_ff <= {16'h0000, param_ff};
      end else if (ADDR == aiobo_pkg::REG_BRKFN) begin
         rdata_ff <= {24'h000000, brkfn_ff};
      end else if (ADDR == aiobo_pkg::REG_BRKT0) begin
         rdata_ff <= {t_close_ff, t_lift_ff};
      end else if (ADDR == aiobo_pkg::REG_BRKT1) begin
         rdata_ff <= {t_fade_ff, t_rise_ff};
      end else if (ADDR == aiobo_pkg::REG_STATUS) begin
         rdata_ff <= {23'h000000, fault_ff, torque_en_ff, brake_out_ff, BRAKE_PHASE};
      end else if (ADDR == aiobo_pkg::REG_IRQ_STAT) begin
         rdata_ff <= {28'h0000000, irq_stat_ff};
      end else if (ADDR == aiobo_pkg::REG_IRQ_EN) begin
         rdata_ff <= {28'h0000000, irq_en_ff};
      end else if (ADDR == aiobo_pkg::REG_REF) begin
         rdata_ff <= {REF_DATA[1], REF_DATA[0]};
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end
   assign RDATA = rdata_ff;

   // Sticky events; a new event beats a clear in the same cycle
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         irq_stat_ff <= '0;
         fault_ff <= '0;
      end else begin
         if (WR && ADDR == aiobo_pkg::REG_IRQ_CLR) begin
            irq_stat_ff <= (irq_stat_ff & ~WDATA[aiobo_pkg::EV_N-1:0]) | ev_set;
         end else begin
            irq_stat_ff <= irq_stat_ff | ev_set;
         end
         fault_ff <= (err_rst ? '0 : fault_ff) | ev_set;
      end
   end
   assign IRQ = |(irq_stat_ff & irq_en_ff);
   assign CABLE_BREAK_ERR = fault_ff[aiobo_pkg::EV_CB0] | fault_ff[aiobo_pkg::EV_CB1];
   assign CABLE_BREAK_REACTION = ctrl_ff[aiobo_pkg::CTRL_REAC_LSB +: 2];

   // Sample-rate tick generators
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         fb_cnt_ff <= 18'h00000;
         ms_cnt_ff <= 18'h00000;
      end else begin
         fb_cnt_ff <= fb_tick ? 18'h00000 : fb_cnt_ff + 18'h00001;
         ms_cnt_ff <= ms_tick ? 18'h00000 : ms_cnt_ff + 18'h00001;
      end
   end
   assign fb_tick = (fb_cnt_ff == 18'(FB_CYCLES - 1));
   assign ms_tick = (ms_cnt_ff == 18'(MS_CYCLES - 1));

   // Pin synchronisers
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         adc_s1_ff <= '0;
         adc_s2_ff <= '0;
         sense_s1_ff <= 2'h0;
         sense_s2_ff <= 2'h0;
      end else begin
         adc_s1_ff <= ADC_DATA;
         adc_s2_ff <= adc_s1_ff;
         sense_s1_ff <= {BRK_SENSE.current_ok, BRK_SENSE.wire_ok};
         sense_s2_ff <= sense_s1_ff;
      end
   end

   // Per-input sampling, filtering, routing and cable-break check
   for (genvar i = 0; i < 2; i++) begin : g_ain
      logic [15:0] ip_cnt_ff;
      logic signed [15:0] filt_ff;
      logic signed [16:0] diff;
      logic [2:0] shift;
      logic fb_use, func_use, ip_due;
      assign fb_use = ctrl_ff[aiobo_pkg::CTRL_FB_LSB + i];
      assign func_use = ctrl_ff[aiobo_pkg::CTRL_FUNC_LSB + i];
      assign shift = filt_cfg_ff[3*i +: 3];
      assign ip_due = TCTRL_TICK && (ip_cnt_ff == 16'h0000);
      assign diff = 17'($signed(adc_s2_ff[i])) - 17'(filt_ff);
      always_comb begin
         if (direct) begin
            sample[i] = ip_due;
         end else if (fb_use) begin
            sample[i] = fb_tick;
         end else if (func_use) begin
            sample[i] = ms_tick;
         end else begin
            sample[i] = 1'b0;
         end
      end
      always_ff @(posedge CLK) begin
         if (!RESET_N) begin
            ip_cnt_ff <= 16'h0000;
         end else if (!direct) begin
            ip_cnt_ff <= 16'h0000;
         end else if (TCTRL_TICK) begin
            ip_cnt_ff <= (ip_cnt_ff >= ipts_ff) ? 16'h0000 : ip_cnt_ff + 16'h0001;
         end
      end
      always_ff @(posedge CLK) begin
         if (!RESET_N) begin
            filt_ff <= 16'sh0000;
         end else if (sample[i]) begin
            filt_ff <= filt_ff + 16'(diff >>> shift);
         end
      end
      always_ff @(posedge CLK) begin
         if (!RESET_N) begin
            REF_DATA[i] <= 16'h0000;
            PROF_REF_VALID[i] <= 1'b0;
            DIRECT_REF_VALID[i] <= 1'b0;
            ADC_SAMPLE[i] <= 1'b0;
         end else begin
            ADC_SAMPLE[i] <= sample[i];
            PROF_REF_VALID[i] <= !direct && sample[i];
            DIRECT_REF_VALID[i] <= direct && TCTRL_TICK;
            if (direct ? TCTRL_TICK : sample[i]) begin
               REF_DATA[i] <= filt_ff;
            end
         end
      end
      assign ev_set[i] = sample[i] && ($signed(adc_s2_ff[i]) < $signed(thr_ff[i]));
   end

   // Analogue outputs: source select, filter, scale and offset
   for (genvar j = 0; j < 2; j++) begin : g_aout
      logic signed [15:0] ofilt_ff;
      logic signed [16:0] odiff;
      logic signed [31:0] prod;
      always_comb begin
         case (aiobo_pkg::aiobo_aosel_t'(aosel_ff[4*j +: 4]))
            aiobo_pkg::AO_SPEED: ao_src[j] = SRC.speed;
            aiobo_pkg::AO_TORQUE: ao_src[j] = SRC.torque;
            aiobo_pkg::AO_RMS_CURRENT_SOURCE: ao_src[j] = SRC.rms_current_source;
            aiobo_pkg::AO_PARAM: ao_src[j] = param_ff;
            aiobo_pkg::AO_POS: ao_src[j] = SRC.position;
            aiobo_pkg::AO_VDC: ao_src[j] = SRC.dc_link_voltage_source;
            aiobo_pkg::AO_MODPOS: ao_src[j] = SRC.modpos;
            aiobo_pkg::AO_POWER: ao_src[j] = SRC.power;
            aiobo_pkg::AO_APPPOW: ao_src[j] = SRC.apppower;
            default: ao_src[j] = 16'h0000;
         endcase
      end
      assign odiff = 17'($signed(ao_src[j])) - 17'(ofilt_ff);
      assign prod = ofilt_ff * $signed(ao_scale_ff[j]);
      always_ff @(posedge CLK) begin
         if (!RESET_N) begin
            ofilt_ff <= 16'sh0000;
            AOUT[j] <= 16'h0000;
         end else if (fb_tick) begin
            ofilt_ff <= ofilt_ff + 16'(odiff >>> filt_cfg_ff[6 + 3*j +: 3]);
            AOUT[j] <= prod[aiobo_pkg::SCALE_FRAC +: 16] + ao_off_ff[j];
         end
      end
   end

   // Brake supervision, only on the dedicated output
   assign cur_bad = sup_active && (brk_ff == aiobo_pkg::BRK_OPEN) && !sense_s2_ff[1];
   assign wire_bad = sup_active && (brk_ff == aiobo_pkg::BRK_CLOSED) && !sense_s2_ff[0];
   assign ev_set[aiobo_pkg::EV_CUR] = cur_bad;
   assign ev_set[aiobo_pkg::EV_WIRE] = wire_bad;

   // Brake sequencer; same in speed and position control
   always_comb begin
      nxt_brk = brk_ff;
      case (brk_ff)
         aiobo_pkg::BRK_CLOSED:
            if (seq_run && BRAKE_RELEASE_REQ && !(|fault_ff[3:2])) begin
               nxt_brk = aiobo_pkg::BRK_RISE;
            end
         aiobo_pkg::BRK_RISE:
            if (tmr_ff >= t_rise_ff) begin
               nxt_brk = aiobo_pkg::BRK_LIFT;
            end
         aiobo_pkg::BRK_LIFT:
            if (tmr_ff >= t_lift_ff) begin
               nxt_brk = aiobo_pkg::BRK_OPEN;
            end
         aiobo_pkg::BRK_OPEN:
            if (!seq_run || !BRAKE_RELEASE_REQ || cur_bad) begin
               nxt_brk = aiobo_pkg::BRK_CLOSING;
            end
         aiobo_pkg::BRK_CLOSING:
            if (tmr_ff >= t_close_ff) begin
               nxt_brk = aiobo_pkg::BRK_FADE;
            end
         aiobo_pkg::BRK_FADE:
            if (tmr_ff >= t_fade_ff) begin
               nxt_brk = aiobo_pkg::BRK_CLOSED;
            end
         default: nxt_brk = aiobo_pkg::BRK_CLOSED;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         brk_ff <= aiobo_pkg::BRK_CLOSED;
         tmr_ff <= 16'h0000;
      end else begin
         brk_ff <= nxt_brk;
         if (nxt_brk != brk_ff) begin
            tmr_ff <= 16'h0000;
         end else if (ms_tick && tmr_ff != 16'hffff) begin
            tmr_ff <= tmr_ff + 16'h0001;
         end
      end
   end

   always_comb begin
      case (brk_ff)
         aiobo_pkg::BRK_RISE: BRAKE_PHASE = 3'h1;
         aiobo_pkg::BRK_LIFT: BRAKE_PHASE = 3'h2;
         aiobo_pkg::BRK_OPEN: BRAKE_PHASE = 3'h3;
         aiobo_pkg::BRK_CLOSING: BRAKE_PHASE = 3'h4;
         aiobo_pkg::BRK_FADE: BRAKE_PHASE = 3'h5;
         default: BRAKE_PHASE = 3'h0;
      endcase
   end

   // Brake pin drivers
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         brake_out_ff <= 1'b0;
         dout_brake_ff <= 1'b0;
         torque_en_ff <= 1'b0;
      end else begin
         if (brk_fn_sel) begin
            brake_out_ff <= (nxt_brk == aiobo_pkg::BRK_LIFT) || (nxt_brk == aiobo_pkg::BRK_OPEN);
         end else begin
            brake_out_ff <= FUNC_LEVEL;
         end
         dout_brake_ff <= dig_brake && !brk_fn_sel &&
            ((nxt_brk == aiobo_pkg::BRK_LIFT) || (nxt_brk == aiobo_pkg::BRK_OPEN));
         torque_en_ff <= (nxt_brk != aiobo_pkg::BRK_CLOSED);
      end
   end
   assign BRAKE_OUT = brake_out_ff;
   assign DOUT_BRAKE = dout_brake_ff;
   assign TORQUE_EN = torque_en_ff;

   // Checks
   direct_ref_gate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      DIRECT_REF_VALID[0] |-> $past(direct) && !PROF_REF_VALID[0])
      else $error("direct reference pulse outside direct path");
   fb_period_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (sample[0] && !direct && ctrl_ff[aiobo_pkg::CTRL_FB_LSB]) |-> fb_tick)
      else $error("feedback input sampled off its period");
   func_period_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (sample[1] && !direct && !ctrl_ff[aiobo_pkg::CTRL_FB_LSB + 1]) |-> ms_tick)
      else $error("function input sampled off the 1 ms tick");
   direct_rate_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (direct && sample[0]) |-> TCTRL_TICK && g_ain[0].ip_cnt_ff == 16'h0000)
      else $error("direct sample not on interpolation slot");
   cable_break_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (sample[1] && $signed(adc_s2_ff[1]) < $signed(thr_ff[1])) |=> fault_ff[1] && irq_stat_ff[1])
      else $error("cable break not flagged");
   fault_latch_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (fault_ff[0] && !err_rst) |=> fault_ff[0])
      else $error("fault flag dropped without error reset");
   param_src_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (aosel_ff[3:0] == 4'h4) |-> ao_src[0] == param_ff)
      else $error("parameter source not routed");
   rise_to_lift_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (brk_ff == aiobo_pkg::BRK_RISE && tmr_ff >= t_rise_ff) |=>
      brk_ff == aiobo_pkg::BRK_LIFT ##1 BRAKE_OUT || !brk_fn_sel)
      else $error("rise time end did not lift brake");
   pin_follow_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      !brk_fn_sel |=> BRAKE_OUT == $past(FUNC_LEVEL))
      else $error("brake pin not following selected function");
   no_sup_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(fault_ff[aiobo_pkg::EV_CUR]) |-> $past(sup_active))
      else $error("current fault without supervision");
   open_c: cover property (@(posedge CLK) brk_ff == aiobo_pkg::BRK_OPEN);
   cable_c: cover property (@(posedge CLK) ev_set[0]);
   direct_c: cover property (@(posedge CLK) DIRECT_REF_VALID[1]);
   cur_fault_c: cover property (@(posedge CLK) cur_bad);
endmodule // aiobo_top
`default_nettype wire

// >>> shared/aiobo_pkg.sv
// Constants and types shared by the analogue I/O and brake output block
package aiobo_pkg;
   // Clock and timing
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned FB_PERIOD_US = 125;
   localparam int unsigned FUNC_PERIOD_MS = 1;
   localparam int unsigned FB_CYCLES = (FB_PERIOD_US * 1000000) / CLK_PERIOD_PS;
   localparam int unsigned MS_CYCLES = (FUNC_PERIOD_MS * 1000000000) / CLK_PERIOD_PS;

   // Register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FILT = 8'h04;
   localparam logic [7:0] REG_IPTS = 8'h08;
   localparam logic [7:0] REG_THR0 = 8'h0c;
   localparam logic [7:0] REG_THR1 = 8'h10;
   localparam logic [7:0] REG_AOSEL = 8'h14;
   localparam logic [7:0] REG_AOSC0 = 8'h18;
   localparam logic [7:0] REG_AOSC1 = 8'h1c;
   localparam logic [7:0] REG_PARAM = 8'h20;
   localparam logic [7:0] REG_BRKFN = 8'h24;
   localparam logic [7:0] REG_BRKT0 = 8'h28;
   localparam logic [7:0] REG_BRKT1 = 8'h2c;
   localparam logic [7:0] REG_STATUS = 8'h30;
   localparam logic [7:0] REG_IRQ_STAT = 8'h34;
   localparam logic [7:0] REG_IRQ_EN = 8'h38;
   localparam logic [7:0] REG_IRQ_CLR = 8'h3c;
   localparam logic [7:0] REG_ERR_RST = 8'h40;
   localparam logic [7:0] REG_REF = 8'h44;

   // Control register fields
   localparam int unsigned CTRL_DIRECT_BIT = 0;
   localparam int unsigned CTRL_SUP_BIT = 1;
   localparam int unsigned CTRL_FB_LSB = 2;
   localparam int unsigned CTRL_FUNC_LSB = 4;
   localparam int unsigned CTRL_REAC_LSB = 6;
   localparam int unsigned CTRL_DIGBRK_BIT = 8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [15:0] SCALE_RESET = 16'h0100;
   localparam int unsigned SCALE_FRAC = 8;

   // Event bits: cable break 0, cable break 1, brake current, brake wire
   localparam int unsigned EV_CB0 = 0;
   localparam int unsigned EV_CB1 = 1;
   localparam int unsigned EV_CUR = 2;
   localparam int unsigned EV_WIRE = 3;
   localparam int unsigned EV_N = 4;

   localparam logic [7:0] BRAKE_FUNC_CODE = 8'h02;

   typedef enum logic [3:0] {
      AO_NONE = 4'h0, AO_SPEED = 4'h1, AO_TORQUE = 4'h2, AO_RMS_CURRENT_SOURCE = 4'h3,
      AO_PARAM = 4'h4, AO_POS = 4'h5, AO_VDC = 4'h6, AO_MODPOS = 4'h7,
      AO_POWER = 4'h8, AO_APPPOW = 4'h9
   } aiobo_aosel_t;

   typedef enum logic [5:0] {
      BRK_CLOSED = 6'h01, BRK_RISE = 6'h02, BRK_LIFT = 6'h04,
      BRK_OPEN = 6'h08, BRK_CLOSING = 6'h10, BRK_FADE = 6'h20
   } aiobo_brk_state_t;

   typedef struct packed {
      logic signed [15:0] speed;
      logic signed [15:0] torque;
      logic signed [15:0] rms_current_source;
      logic signed [15:0] position;
      logic signed [15:0] dc_link_voltage_source;
      logic signed [15:0] modpos;
      logic signed [15:0] power;
      logic signed [15:0] apppower;
   } aiobo_src_t;

   typedef struct packed {
      logic current_ok;
      logic wire_ok;
   } aiobo_brk_sense_t;
endpackage

// >>> testbench/aiobo_far_side.sv
// Far-side model: analogue sensors and motor holding brake sense lines
`timescale 1ns/10ps
`default_nettype none
module aiobo_far_side (
   // Test controls
   input wire logic [1:0] adc_low,
   input wire logic lose_current,
   // Sensor and brake sense pins
   output logic [1:0][15:0] ADC_DATA,
   output var aiobo_pkg::aiobo_brk_sense_t BRK_SENSE
);
   // Broken sensor wire reads near zero volts
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         ADC_DATA[i] = adc_low[i] ? 16'h0010 : 16'h4000;
      end
   end
   assign BRK_SENSE = '{current_ok: ~lose_current, wire_ok: 1'b1};
endmodule // aiobo_far_side
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the analogue I/O and brake output block
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0, reset_n = 1'b0, wr, rd, tick, req, lose_current, func_level, irq;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [1:0] adc_low, prof_valid, dir_valid, reaction, adc_sample;
   logic [1:0][15:0] adc, ref_data, aout;
   logic cb_err, brake_out, torque_en, dout_brake;
   logic [2:0] phase;
   logic [15:0] ao_exp [10] = '{16'h0, 16'h0111, 16'h0222, 16'h0333, 16'h0999,
      16'h0444, 16'h0555, 16'h0666, 16'h0777, 16'h0888};
   logic [2:0] seq [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h0};
   aiobo_pkg::aiobo_src_t src;
   aiobo_pkg::aiobo_brk_sense_t sense;
   int n_fail = 0, n_compared = 0;
   always #2.5 clk = ~clk;
   aiobo_top #(.FB_CYCLES(20), .MS_CYCLES(50)) dut (.CLK(clk), .RESET_N(reset_n),
      .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq),
      .ADC_DATA(adc), .TCTRL_TICK(tick), .ADC_SAMPLE(adc_sample), .REF_DATA(ref_data),
      .PROF_REF_VALID(prof_valid), .DIRECT_REF_VALID(dir_valid), .CABLE_BREAK_ERR(cb_err),
      .CABLE_BREAK_REACTION(reaction), .SRC(src), .AOUT(aout),
      .BRAKE_RELEASE_REQ(req), .FUNC_LEVEL(func_level), .BRK_SENSE(sense),
      .BRAKE_OUT(brake_out), .DOUT_BRAKE(dout_brake), .TORQUE_EN(torque_en), .BRAKE_PHASE(phase));
   aiobo_far_side far (.adc_low(adc_low), .lose_current(lose_current),
      .ADC_DATA(adc), .BRK_SENSE(sense));
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   task final_report;
      $display("compared=%0d failed=%0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial begin
      {wr, rd, tick, req, lose_current, func_level} = '0;
      addr = '0;
      wdata = '0;
      adc_low = 2'b00;
      src = {16'h0111, 16'h0222, 16'h0333, 16'h0444, 16'h0555, 16'h0666, 16'h0777, 16'h0888};
      repeat (3) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(aiobo_pkg::REG_AOSC0, 32'h0000_0100);
      rd_chk(8'hfc, 32'h0);
      chk({29'h0, phase}, 32'h0);
      wr_reg(aiobo_pkg::REG_FILT, 32'h0);
      wr_reg(aiobo_pkg::REG_PARAM, 32'h0999);
      for (int k = 0; k < 10; k++) begin
         wr_reg(aiobo_pkg::REG_AOSEL, {24'h0, k[3:0], k[3:0]});
         cyc(45);
         chk({16'h0, aout[0]}, {16'h0, ao_exp[k]});
         chk({16'h0, aout[1]}, {16'h0, ao_exp[k]});
      end
      wr_reg(aiobo_pkg::REG_THR0, 32'h0100);
      wr_reg(aiobo_pkg::REG_THR1, 32'h0100);
      wr_reg(aiobo_pkg::REG_IRQ_EN, 32'h3);
      wr_reg(aiobo_pkg::REG_CTRL, 32'h8c);
      cyc(1);
      chk({30'h0, reaction}, 32'h2);
      for (int i = 0; i < 2; i++) begin
         adc_low <= 2'(1 << i);
         cyc(60);
         chk({31'h0, cb_err}, 32'h1);
         chk({31'h0, irq}, 32'h1);
         rd_chk(aiobo_pkg::REG_IRQ_STAT, 32'(1 << i));
         adc_low <= 2'b00;
         cyc(60);
         chk({31'h0, cb_err}, 32'h1);
         wr_reg(aiobo_pkg::REG_IRQ_CLR, 32'hf);
         wr_reg(aiobo_pkg::REG_ERR_RST, 32'h1);
         cyc(2);
         chk({30'h0, cb_err, irq}, 32'h0);
      end
      wr_reg(aiobo_pkg::REG_IPTS, 32'h0);
      wr_reg(aiobo_pkg::REG_CTRL, 32'h1);
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
      #1;
      chk({30'h0, dir_valid}, 32'h3);
      chk({30'h0, prof_valid}, 32'h0);
      chk({30'h0, adc_sample}, 32'h3);
      chk({16'h0, ref_data[0]}, 32'h4000);
      wr_reg(aiobo_pkg::REG_BRKT0, 32'h0);
      wr_reg(aiobo_pkg::REG_BRKT1, 32'h0);
      wr_reg(aiobo_pkg::REG_BRKFN, 32'h2);
      @(posedge clk);
      req <= 1'b1;
      for (int j = 0; j < 6; j++) begin
         @(posedge clk);
         if (j == 2)
            req <= 1'b0;
         #1;
         chk({29'h0, phase}, {29'h0, seq[j]});
         if (j == 2)
            chk({30'h0, brake_out, torque_en}, 32'h3);
      end
      wr_reg(aiobo_pkg::REG_CTRL, 32'h2);
      req <= 1'b1;
      cyc(10);
      chk({29'h0, phase}, 32'h3);
      lose_current <= 1'b1;
      cyc(10);
      rd_chk(aiobo_pkg::REG_IRQ_STAT, 32'h4);
      chk({29'h0, phase}, 32'h0);
      wr_reg(aiobo_pkg::REG_BRKFN, 32'h0);
      wr_reg(aiobo_pkg::REG_ERR_RST, 32'h1);
      wr_reg(aiobo_pkg::REG_IRQ_CLR, 32'hf);
      wr_reg(aiobo_pkg::REG_CTRL, 32'h102);
      cyc(10);
      chk({29'h0, phase}, 32'h3);
      chk({29'h0, brake_out, dout_brake, torque_en}, 32'h3);
      rd_chk(aiobo_pkg::REG_IRQ_STAT, 32'h0);
      @(posedge clk);
      func_level <= 1'b1;
      cyc(2);
      chk({31'h0, brake_out}, 32'h1);
      final_report;
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      final_report;
   end
endmodule // testbench
`default_nettype wire
